// ==== common/srm_defs.svh ====
// register map, field positions, reset values and timing counts of the start-up sequencer
`ifndef SRM_DEFS_SVH
`define SRM_DEFS_SVH

// =============================================================
// clock
`define SRM_CLK_MHZ        50

// =============================================================
// times in their own unit, then cycle counts at the clock rate
`define SRM_POD_US         285
`define SRM_DISCH_US       125
`define SRM_SAMPLE_US      32
`define SRM_RAMP_US        1500
`define SRM_RAMP_DONE_US   2000
`define SRM_PG_DELAY_US    1060
`define SRM_POD_CYC        (`SRM_POD_US * `SRM_CLK_MHZ)
`define SRM_DISCH_CYC      (`SRM_DISCH_US * `SRM_CLK_MHZ)
`define SRM_SAMPLE_CYC     (`SRM_SAMPLE_US * `SRM_CLK_MHZ)
`define SRM_RAMP_CYC       (`SRM_RAMP_US * `SRM_CLK_MHZ)
`define SRM_RAMP_DONE_CYC  (`SRM_RAMP_DONE_US * `SRM_CLK_MHZ)
`define SRM_PG_DELAY_CYC   (`SRM_PG_DELAY_US * `SRM_CLK_MHZ)
`define SRM_CNT_W          17

// =============================================================
// register byte offsets
`define SRM_OFS_CTRL       4'h0
`define SRM_OFS_STATUS     4'h4
`define SRM_OFS_INT_STAT   4'h8
`define SRM_OFS_INT_MASK   4'hc

// =============================================================
// fields and reset values
`define SRM_CTRL_EN_BIT    0
`define SRM_CTRL_RST       32'h0000_0001
`define SRM_INT_MASK_RST   4'h0
`define SRM_N_EVT          4
`define SRM_RESP_OKAY      2'h0
`define SRM_RESP_SLVERR    2'h2

// =============================================================
// strap detector codes (0 = shorted low ... 5 = shorted high)
`define SRM_STRAP_FCCM_600 3'h0
`define SRM_STRAP_FCCM_800 3'h1
`define SRM_STRAP_FCCM_1K  3'h2
`define SRM_STRAP_SKIP_1K  3'h3
`define SRM_STRAP_SKIP_800 3'h4
`define SRM_STRAP_SKIP_600 3'h5

`endif

// ==== common/srm_pkg.sv ====
// types shared by the start-up sequencer files
package srm_pkg;

	// =============================================================
	// sequence states
	typedef enum logic [2:0] {
		SRM_ST_WAIT,
		SRM_ST_POD,
		SRM_ST_SOFT,
		SRM_ST_PGDLY,
		SRM_ST_RUN
	} srm_state_t;

	// =============================================================
	// switching frequency choice
	typedef enum logic [1:0] {
		SRM_F600,
		SRM_F800,
		SRM_F1000
	} srm_freq_t;

	// latched light-load mode and frequency
	typedef struct packed {
		logic      fccm;
		srm_freq_t freq;
	} srm_mode_t;

	// sticky event bits, same layout in status and mask registers
	typedef struct packed {
		logic pg_rise;
		logic ext_ramp_done;
		logic int_ramp_done;
		logic detect_done;
	} srm_evt_t;

endpackage

// ==== src/srm_sync.sv ====
// three-stage synchroniser for pin-level inputs; change accepted when stages two and three agree
module srm_sync
	import srm_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// asynchronous level in, clean level out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic q_r;
			// s1 feeds only s2, so metastability never reaches the compare
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					q_r  <= 1'b0;
				end else begin
					s1_r <= i_d[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) q_r <= s3_r;
				end
			end
			assign o_q[g] = q_r;
		end
	endgenerate

endmodule

// ==== src/srm_count.sv ====
// saturating cycle counter with synchronous clear, used to time every delay
`include "srm_defs.svh"
module srm_count
	import srm_pkg::*;
(
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// control
	input  wire logic                  i_clr,
	input  wire logic                  i_en,
	// count value
	output logic [`SRM_CNT_W-1:0]      o_cnt
);

	logic [`SRM_CNT_W-1:0] cnt_r;
	wire                   at_max = &cnt_r;

	// saturating so a long wait never wraps back into a window compare
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else if (i_clr) begin
			cnt_r <= '0;
		end else if (i_en && !at_max) begin
			cnt_r <= cnt_r + `SRM_CNT_W'(1);
		end
	end

	assign o_cnt = cnt_r;

endmodule

// ==== src/srm_sequencer.sv ====
// start-up sequencer: power-on delay, pin detection, strap latch, ramps, power good, AXI4-Lite registers
`include "srm_defs.svh"

// Notes on behaviour
// - fixed power-on delay after bias valid; detection finishes before any ramp.
// - internal soft-start ramp runs about 1.5 ms when no slower ramp exists.
// - with both ramps present, the slower one governs feedback start-up.
// - soft-start/reference pin discharged during power-on delay so ramps start at zero.
// - midway through the delay, pin pulled low for 125 us before sampling.
// - comparator against 89 percent reference judged over 32 us window.
// - without external reference, thresholds first use internal reference.
// - without external reference, thresholds move to pin after power good rises.
// - soft-start case: power good 1.06 ms after both ramp-done indications.
// - internal ramp counted finished 2 ms after it starts.
// - external ramp done when feedback reaches reference minus 50 mV.
// - external reference: thresholds always from pin, only internal ramp used.
// - external reference case: power good 1.06 ms after internal ramp done.
// - mode and frequency latched during delay; later strap changes ignored.
// - open strap defaults to 600 kHz with skip at light load.
// - six strap levels: high three skip 600/800/1000, low three forced 1000/800/600.
module srm_sequencer
	import srm_pkg::*;
#(
	parameter int POD_CYC       = `SRM_POD_CYC,
	parameter int DISCH_CYC     = `SRM_DISCH_CYC,
	parameter int RAMP_CYC      = `SRM_RAMP_CYC,
	parameter int RAMP_DONE_CYC = `SRM_RAMP_DONE_CYC,
	parameter int PG_DELAY_CYC  = `SRM_PG_DELAY_CYC
) (
	// clock and reset (reset held while the converter is disabled)
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// analog-side inputs, asynchronous to i_clk
	input  wire logic        i_bias_ok,
	input  wire logic        i_pin_above_89,
	input  wire logic        i_feedback_near_ref,
	input  wire logic [2:0]  i_strap_code,
	// analog-side controls
	output logic             o_pin_discharge,
	output logic             o_int_ramp_run,
	output logic             o_soft_start,
	output logic             o_ext_ref,
	output logic             o_thresh_from_pin,
	output logic             o_power_good_output,
	output srm_mode_t        o_mode,
	// interrupt
	output logic             o_intr,
	// axi4-lite write address
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [3:0]  i_awaddr,
	// axi4-lite write data
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	// axi4-lite write response
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// axi4-lite read address
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [3:0]  i_araddr,
	// axi4-lite read data
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp
);

	// =============================================================
	// window edges inside the power-on delay
	// discharge ends at the midpoint, sampling starts there
	localparam int SMP_START = POD_CYC / 2;
	localparam int DIS_START = SMP_START - DISCH_CYC;
	localparam int SMP_END   = SMP_START + `SRM_SAMPLE_CYC;

	localparam logic [`SRM_CNT_W-1:0] C_DIS_START = `SRM_CNT_W'(DIS_START);
	localparam logic [`SRM_CNT_W-1:0] C_SMP_START = `SRM_CNT_W'(SMP_START);
	localparam logic [`SRM_CNT_W-1:0] C_SMP_LAST  = `SRM_CNT_W'(SMP_END - 1);
	localparam logic [`SRM_CNT_W-1:0] C_POD_LAST  = `SRM_CNT_W'(POD_CYC - 1);
	localparam logic [`SRM_CNT_W-1:0] C_RAMP      = `SRM_CNT_W'(RAMP_CYC);
	localparam logic [`SRM_CNT_W-1:0] C_RDONE     = `SRM_CNT_W'(RAMP_DONE_CYC - 1);
	localparam logic [`SRM_CNT_W-1:0] C_PGD_LAST  = `SRM_CNT_W'(PG_DELAY_CYC - 1);

	// =============================================================
	// synchronised inputs
	logic       bias_ok_s;
	logic       pin_above_s;
	logic       feedback_near_s;
	logic [2:0] strap_s;

	// single-bit pins share one synchroniser instance
	srm_sync #(.W(3)) u_sync_lvl (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_bias_ok, i_pin_above_89, i_feedback_near_ref}),
		.o_q   ({bias_ok_s, pin_above_s, feedback_near_s})
	);

	// strap code may be seen mid-change; only the window-end value is kept
	srm_sync #(.W(3)) u_sync_strap (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (i_strap_code),
		.o_q   (strap_s)
	);

	// =============================================================
	// registers
	srm_state_t            state_r;
	srm_state_t            state_nxt;
	logic                  ext_ref_r;
	logic                  det_acc_r;
	logic                  int_done_r;
	logic                  ext_done_r;
	logic                  pg_r;
	srm_mode_t             mode_r;
	logic [31:0]           ctrl_r;
	srm_evt_t              int_stat_r;
	srm_evt_t              int_mask_r;
	logic [`SRM_CNT_W-1:0] cnt;

	// =============================================================
	// sequence counter, cleared on every state change
	wire seq_clr = (state_r != state_nxt);

	srm_count u_count (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_clr (seq_clr),
		.i_en  (state_r != SRM_ST_WAIT),
		.o_cnt (cnt)
	);

	// =============================================================
	// window decodes
	wire in_pod     = (state_r == SRM_ST_POD);
	wire in_soft    = (state_r == SRM_ST_SOFT);
	wire dis_win    = in_pod && (cnt >= C_DIS_START) && (cnt < C_SMP_START);
	wire smp_first  = in_pod && (cnt == C_SMP_START);
	wire smp_win    = in_pod && (cnt >= C_SMP_START) && (cnt <= C_SMP_LAST);
	wire smp_last   = in_pod && (cnt == C_SMP_LAST);
	wire pod_last   = in_pod && (cnt == C_POD_LAST);
	wire ramp_hit   = in_soft && (cnt == C_RDONE);
	wire pgd_last   = (state_r == SRM_ST_PGDLY) && (cnt == C_PGD_LAST);
	wire start_ok   = bias_ok_s && ctrl_r[`SRM_CTRL_EN_BIT];
	// outcome of the comparator over the whole window, final cycle included
	wire det_result = det_acc_r && pin_above_s;
	// both ramps finished; with external reference only the internal one counts
	wire ramps_done = int_done_r && (ext_ref_r || ext_done_r);

	// =============================================================
	// strap decode; open or unknown codes fall back to skip at 600 kHz
	srm_mode_t strap_mode;
	always_comb begin
		case (strap_s)
			`SRM_STRAP_SKIP_600: strap_mode = '{fccm: 1'b0, freq: SRM_F600};
			`SRM_STRAP_SKIP_800: strap_mode = '{fccm: 1'b0, freq: SRM_F800};
			`SRM_STRAP_SKIP_1K:  strap_mode = '{fccm: 1'b0, freq: SRM_F1000};
			`SRM_STRAP_FCCM_1K:  strap_mode = '{fccm: 1'b1, freq: SRM_F1000};
			`SRM_STRAP_FCCM_800: strap_mode = '{fccm: 1'b1, freq: SRM_F800};
			`SRM_STRAP_FCCM_600: strap_mode = '{fccm: 1'b1, freq: SRM_F600};
			default:             strap_mode = '{fccm: 1'b0, freq: SRM_F600};
		endcase
	end

	// =============================================================
	// next state of the start-up sequence
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SRM_ST_WAIT: begin
				if (start_ok) state_nxt = SRM_ST_POD;
			end
			SRM_ST_POD: begin
				// no ramp until detection, strap latch and init are all behind us
				if (pod_last) state_nxt = SRM_ST_SOFT;
			end
			SRM_ST_SOFT: begin
				if (ramps_done) state_nxt = SRM_ST_PGDLY;
			end
			SRM_ST_PGDLY: begin
				if (pgd_last) state_nxt = SRM_ST_RUN;
			end
			SRM_ST_RUN: begin
				state_nxt = SRM_ST_RUN;
			end
			default: begin
				state_nxt = SRM_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) state_r <= SRM_ST_WAIT;
		else       state_r <= state_nxt;
	end

	// =============================================================
	// pin detection and strap latch, both taken once per power-up
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			det_acc_r <= 1'b0;
			ext_ref_r <= 1'b0;
			mode_r    <= '{fccm: 1'b0, freq: SRM_F600};
		end else begin
			if (smp_first)    det_acc_r <= pin_above_s;
			else if (smp_win) det_acc_r <= det_result;
			if (smp_last) begin
				ext_ref_r <= det_result;
				mode_r    <= strap_mode;
			end
		end
	end

	// =============================================================
	// ramp-done flags and power good
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_done_r <= 1'b0;
			ext_done_r <= 1'b0;
			pg_r       <= 1'b0;
		end else begin
			if (ramp_hit) int_done_r <= 1'b1;
			if (in_soft && feedback_near_s) ext_done_r <= 1'b1;
			if (pgd_last) pg_r <= 1'b1;
		end
	end

	// =============================================================
	// analog controls
	assign o_pin_discharge     = dis_win;
	// internal ramp climbs for its nominal time, then holds
	assign o_int_ramp_run      = in_soft && (cnt < C_RAMP);
	assign o_soft_start        = in_soft;
	assign o_ext_ref           = ext_ref_r;
	// internal reference until power good rises, unless a source was found
	assign o_thresh_from_pin   = ext_ref_r || pg_r;
	assign o_power_good_output = pg_r;
	assign o_mode              = mode_r;

	// =============================================================
	// events: one-cycle pulses into the sticky status
	srm_evt_t evt;
	assign evt.detect_done   = smp_last;
	assign evt.int_ramp_done = ramp_hit;
	assign evt.ext_ramp_done = in_soft && feedback_near_s && !ext_done_r;
	assign evt.pg_rise       = pgd_last;

	// =============================================================
	// axi4-lite write path: address and data taken in either order
	logic        aw_held_r;
	logic        w_held_r;
	logic [3:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;

	assign o_awready = !aw_held_r && !bvalid_r;
	assign o_wready  = !w_held_r && !bvalid_r;
	wire   aw_take   = i_awvalid && o_awready;
	wire   w_take    = i_wvalid && o_wready;
	wire   wr_go     = aw_held_r && w_held_r && !bvalid_r;
	wire   wr_ctrl   = wr_go && (awaddr_r == `SRM_OFS_CTRL);
	wire   wr_stat   = wr_go && (awaddr_r == `SRM_OFS_INT_STAT) && wstrb_r[0];
	wire   wr_mask   = wr_go && (awaddr_r == `SRM_OFS_INT_MASK) && wstrb_r[0];
	wire   wr_hit    = (awaddr_r == `SRM_OFS_CTRL) || (awaddr_r == `SRM_OFS_STATUS) ||
	                   (awaddr_r == `SRM_OFS_INT_STAT) || (awaddr_r == `SRM_OFS_INT_MASK);
	// only the low lane carries live bits, so only wstrb[0] matters
	wire   [3:0] clr_bits = wr_stat ? wdata_r[3:0] : 4'h0;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 4'h0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `SRM_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= {i_awaddr[3:2], 2'b00};
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				wdata_r  <= i_wdata;
				wstrb_r  <= i_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? `SRM_RESP_OKAY : `SRM_RESP_SLVERR;
			end else if (bvalid_r && i_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign o_bvalid = bvalid_r;
	assign o_bresp  = bresp_r;

	// =============================================================
	// software registers; a hardware event beats a same-cycle clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r     <= `SRM_CTRL_RST;
			int_stat_r <= '0;
			int_mask_r <= `SRM_INT_MASK_RST;
		end else begin
			if (wr_ctrl && wstrb_r[0]) ctrl_r[`SRM_CTRL_EN_BIT] <= wdata_r[`SRM_CTRL_EN_BIT];
			if (wr_mask) int_mask_r <= wdata_r[3:0];
			int_stat_r <= (int_stat_r & ~clr_bits) | evt;
		end
	end

	assign o_intr = |(int_stat_r & int_mask_r);

	// =============================================================
	// axi4-lite read path: one read in flight, answer the edge after the take
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [31:0] rd_mux;
	logic        rd_hit;

	// status word: state, detection, ramps, power good, latched mode
	wire [31:0] status_word = {20'h0_0000, mode_r.fccm, mode_r.freq, o_thresh_from_pin,
	                           pg_r, ext_done_r, int_done_r, ext_ref_r, 1'b0, state_r};

	assign o_arready = !rvalid_r;
	wire   ar_take   = i_arvalid && o_arready;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case ({i_araddr[3:2], 2'b00})
			`SRM_OFS_CTRL:     rd_mux = ctrl_r;
			`SRM_OFS_STATUS:   rd_mux = status_word;
			`SRM_OFS_INT_STAT: rd_mux = {28'h000_0000, int_stat_r};
			`SRM_OFS_INT_MASK: rd_mux = {28'h000_0000, int_mask_r};
			default:           rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `SRM_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_hit ? `SRM_RESP_OKAY : `SRM_RESP_SLVERR;
		end else if (rvalid_r && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign o_rvalid = rvalid_r;
	assign o_rdata  = rdata_r;
	assign o_rresp  = rresp_r;

endmodule

// ==== tb/srm_sequencer_chk.sv ====
// checker: port relations of the start-up sequencer
module srm_sequencer_chk
	import srm_pkg::*;
#(
	parameter int DISCH_CYC     = 40,
	parameter int RAMP_CYC      = 60,
	parameter int RAMP_DONE_CYC = 80,
	parameter int PG_DELAY_CYC  = 50
) (
	// clock and reset
	input wire logic      i_clk,
	input wire logic      i_rst,
	// watched outputs
	input wire logic      o_pin_discharge,
	input wire logic      o_int_ramp_run,
	input wire logic      o_soft_start,
	input wire logic      o_ext_ref,
	input wire logic      o_thresh_from_pin,
	input wire logic      o_power_good_output,
	input wire srm_mode_t o_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [16:0] dis_r;
	logic [16:0] ss_r;
	logic [16:0] gap_r;

	// =============================================================
	// run lengths, counted here so the long windows stay out of the properties
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			dis_r <= '0;
			ss_r <= '0;
			gap_r <= '0;
		end else begin
			dis_r <= o_pin_discharge ? dis_r + 17'h1 : 17'h0;
			ss_r <= o_soft_start ? ss_r + 17'h1 : 17'h0;
			gap_r <= o_soft_start ? 17'h0 : gap_r + 17'h1;
		end
	end

	// =============================================================
	// properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_ramp_start;
		$rose(o_soft_start);
	endsequence
	sequence s_pg_rise;
		$rose(o_power_good_output);
	endsequence
	property p_disch_len;
		$fell(o_pin_discharge) |-> dis_r == DISCH_CYC;
	endproperty
	property p_disch_quiet;
		o_pin_discharge |-> !o_soft_start && !o_power_good_output;
	endproperty
	property p_ramp_start;
		s_ramp_start |-> o_int_ramp_run && !o_pin_discharge;
	endproperty
	property p_ramp_run;
		o_int_ramp_run |-> o_soft_start;
	endproperty
	property p_ramp_len;
		$fell(o_int_ramp_run) |-> ss_r == RAMP_CYC;
	endproperty
	property p_soft_len;
		$fell(o_soft_start) |-> ss_r >= RAMP_DONE_CYC - 1;
	endproperty
	// one cycle of slack either way for the registered flag
	property p_pg_delay;
		s_pg_rise |-> gap_r >= PG_DELAY_CYC - 1 && gap_r <= PG_DELAY_CYC + 1;
	endproperty
	property p_pg_hold;
		o_power_good_output |=> o_power_good_output;
	endproperty
	property p_thresh_int;
		!o_ext_ref && !o_power_good_output |-> !o_thresh_from_pin;
	endproperty
	property p_thresh_pin;
		s_pg_rise |-> ##[0:1] o_thresh_from_pin;
	endproperty
	property p_ext_thresh;
		o_ext_ref && o_soft_start |-> o_thresh_from_pin;
	endproperty
	property p_mode_hold;
		o_soft_start || o_power_good_output |-> $stable(o_mode);
	endproperty
	a_disch_len: assert property (p_disch_len) else $error("discharge length off");
	a_disch_quiet: assert property (p_disch_quiet) else $error("discharge outside delay");
	a_ramp_start: assert property (p_ramp_start) else $error("ramp start bad");
	a_ramp_run: assert property (p_ramp_run) else $error("ramp outside soft start");
	a_ramp_len: assert property (p_ramp_len) else $error("internal ramp length off");
	a_soft_len: assert property (p_soft_len) else $error("soft start too short");
	a_pg_delay: assert property (p_pg_delay) else $error("power good delay off");
	a_pg_hold: assert property (p_pg_hold) else $error("power good dropped");
	a_thresh_int: assert property (p_thresh_int) else $error("threshold not internal");
	a_thresh_pin: assert property (p_thresh_pin) else $error("threshold not moved");
	a_ext_thresh: assert property (p_ext_thresh) else $error("external threshold lost");
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
endmodule

bind srm_sequencer srm_sequencer_chk #(.DISCH_CYC(DISCH_CYC), .RAMP_CYC(RAMP_CYC), .RAMP_DONE_CYC(RAMP_DONE_CYC),
	.PG_DELAY_CYC(PG_DELAY_CYC)) u_chk (.i_clk(i_clk), .i_rst(i_rst), .o_pin_discharge(o_pin_discharge),
	.o_int_ramp_run(o_int_ramp_run), .o_soft_start(o_soft_start), .o_ext_ref(o_ext_ref),
	.o_thresh_from_pin(o_thresh_from_pin), .o_power_good_output(o_power_good_output), .o_mode(o_mode));

// ==== tb/srm_board.sv ====
// board model: soft-start capacitor or external source, feedback ramp
module srm_board (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// board setup and design controls
	input  wire logic       i_ext_src,
	input  wire logic [8:0] i_feedback_lag,
	input  wire logic       i_discharge,
	input  wire logic       i_soft_start,
	// comparator outputs
	output logic            o_pin_above_89,
	output logic            o_feedback_near_ref
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       charge_r = 1'b1;
	logic [8:0] ramp_r = 9'h0;

	// capacitor keeps leftover charge until pulled low, a trap for a missing discharge
	always @(posedge i_clk) begin
		if (i_rst)
			charge_r <= 1'b1;
		else if (i_discharge)
			charge_r <= 1'b0;
		ramp_r <= (i_soft_start && ramp_r != 9'h1ff) ? ramp_r + 9'h1 : (i_soft_start ? ramp_r : 9'h0);
	end
	assign o_pin_above_89 = i_ext_src | charge_r;
	// a long lag makes the capacitor ramp the slower one
	assign o_feedback_near_ref = i_soft_start && ramp_r >= i_feedback_lag;
endmodule

// ==== tb/tb_srm_sequencer.sv ====
// testbench: start-up runs over all strap codes, both reference kinds
module tb_srm_sequencer
	import srm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0, i_rst = 1'b1, i_bias_ok = 1'b0, ext_src = 1'b0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [8:0] feedback_lag = 9'h1e;
	logic [2:0] i_strap_code = 3'h0;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic i_pin_above_89, i_feedback_near_ref, o_pin_discharge, o_int_ramp_run, o_soft_start, o_ext_ref;
	logic o_thresh_from_pin, o_power_good_output, o_intr, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	srm_mode_t o_mode;
	int bad_count = 0, n_checks = 0;
	logic [63:0] exp_q[$];
	logic [63:0] e;

	// =============================================================
	// clock, design and board
	always #10 i_clk = ~i_clk;
	srm_sequencer #(.POD_CYC(4000), .DISCH_CYC(40), .RAMP_CYC(60), .RAMP_DONE_CYC(80), .PG_DELAY_CYC(50)) dut (
		.i_clk, .i_rst, .i_bias_ok, .i_pin_above_89, .i_feedback_near_ref, .i_strap_code, .o_pin_discharge,
		.o_int_ramp_run, .o_soft_start, .o_ext_ref, .o_thresh_from_pin, .o_power_good_output, .o_mode, .o_intr,
		.i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
		.o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
	srm_board u_board (.i_clk(i_clk), .i_rst(i_rst), .i_ext_src(ext_src), .i_feedback_lag(feedback_lag),
		.i_discharge(o_pin_discharge), .i_soft_start(o_soft_start), .o_pin_above_89(i_pin_above_89),
		.o_feedback_near_ref(i_feedback_near_ref));

	// =============================================================
	// compare, verdict and bounded waiting
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic step(inout int n);
		@(posedge i_clk);
		n++;
		if (n > 20000) begin
			bad_count++;
			$display("wrong value at %0t: wait ran out", $time);
			conclude();
		end
	endtask

	// =============================================================
	// register bus master; read expectations go to the queue
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		int n;
		logic da, dw;
		n = 0;
		da = 1'b0;
		dw = 1'b0;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_awaddr <= a;
		i_wdata <= d;
		while (!(da && dw)) begin
			step(n);
			if (o_awready && !da) begin
				da = 1'b1;
				i_awvalid <= 1'b0;
			end
			if (o_wready && !dw) begin
				dw = 1'b1;
				i_wvalid <= 1'b0;
			end
		end
		i_bready <= 1'b1;
		do step(n); while (!o_bvalid);
		i_bready <= 1'b0;
		chk({30'h0, o_bresp}, 32'h0, "write resp");
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] m);
		int n;
		n = 0;
		exp_q.push_back({ex, m});
		i_arvalid <= 1'b1;
		i_araddr <= a;
		do step(n); while (!o_arready);
		i_arvalid <= 1'b0;
		i_rready <= 1'b1;
		do step(n); while (!o_rvalid);
		i_rready <= 1'b0;
	endtask
	// watcher pairs each read answer with the oldest note
	always @(posedge i_clk) begin
		if (o_rvalid && i_rready && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk(o_rdata & e[31:0], e[63:32], "read data");
			chk({30'h0, o_rresp}, 32'h0, "read resp");
		end
	end

	// =============================================================
	// expected mode per strap code; codes 5..7 fall to skip at 600
	function automatic logic [2:0] exp_mode(input logic [2:0] c);
		case (c)
			3'h0: return {1'b1, SRM_F600};
			3'h1: return {1'b1, SRM_F800};
			3'h2: return {1'b1, SRM_F1000};
			3'h3: return {1'b0, SRM_F1000};
			3'h4: return {1'b0, SRM_F800};
			default: return {1'b0, SRM_F600};
		endcase
	endfunction

	// =============================================================
	// one full start-up from reset to power good
	task automatic run(input logic [2:0] c, input logic ext, input logic [8:0] lag, input logic irq);
		int n, ss;
		logic ok;
		n = 0;
		ss = 0;
		i_rst <= 1'b1;
		i_bias_ok <= 1'b0;
		i_strap_code <= c;
		ext_src <= ext;
		feedback_lag <= lag;
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
		axr(4'h0, 32'h1, 32'hffff_ffff);
		// disabled: bias alone must not start the sequence
		axw(4'h0, 32'h0);
		i_bias_ok <= 1'b1;
		repeat (8) @(posedge i_clk);
		axr(4'h4, 32'h0, 32'hfff);
		axw(4'h0, 32'h1);
		axr(4'hc, 32'h0, 32'hf);
		axw(4'hc, {28'h0, irq, 3'h0});
		do step(n); while (!o_soft_start);
		chk({31'h0, o_ext_ref}, {31'h0, ext}, "ext ref");
		chk({31'h0, o_thresh_from_pin}, {31'h0, ext}, "threshold");
		chk({29'h0, o_mode}, {29'h0, exp_mode(c)}, "mode");
		i_strap_code <= 3'($urandom_range(0, 7));
		while (o_soft_start) begin
			step(n);
			ss++;
		end
		ok = ss >= 79 && (ext ? (lag <= 9'h50 || ss < lag) : ss >= lag);
		chk({31'h0, ok}, 32'h1, "soft length");
		do step(n); while (!o_power_good_output);
		step(n);
		step(n);
		chk({29'h0, o_mode}, {29'h0, exp_mode(c)}, "mode held");
		chk({31'h0, o_thresh_from_pin}, 32'h1, "threshold after pg");
		chk({31'h0, o_intr}, {31'h0, irq}, "irq level");
		axr(4'h8, 32'hb, 32'hb);
		axw(4'h8, 32'hf);
		step(n);
		chk({31'h0, o_intr}, 32'h0, "irq cleared");
		axr(4'h8, 32'h0, 32'hf);
	endtask

	// =============================================================
	// main sequence: every strap code, both kinds of reference
	initial begin
		void'($urandom(32'hcfe6c443));
		for (int c = 0; c < 8; c++) begin
			run(c[2:0], c[0], c[2] ? 9'hfa : 9'h1e, c[1]);
			$display("test strap %0d done", c);
		end
		conclude();
	end
endmodule
